// ===== design/mode_control_supply_fault_monitor.sv
// Mode control, supply fault monitor and interrupt front end
`timescale 1ns/100ps
`include "fault_monitor_defines.svh"
module mode_control_supply_fault_monitor
   import fault_monitor_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire reg_req_type reg_req,
   output reg_rsp_type      reg_rsp,
   input  wire logic [7:0]  supply_fault_in,
   input  wire logic [5:0]  status_in,
   input  wire logic        gp_pin_one,
   input  wire logic        gp_pin_two,
   input  wire logic        defaults_reload,
   output logic             buck_standby,
   output logic             sleep_req,
   output logic             soft_reset_req,
   output logic             led_boost_low_freq_osc,
   output logic             supply_fault_evt,
   output logic             int_n
);

   // Edge of a general pin as configured
   function automatic logic gp_edge(input logic is_input,
                                    input logic rising,
                                    input logic now_val,
                                    input logic old_val);
      logic r;
      r = 1'b0;
      if (is_input) begin
         r = rising ? (now_val & ~old_val) : (~now_val & old_val);
      end
      return r;
   endfunction : gp_edge

   // History of the monitored inputs
   logic [7:0]    supply_prev_ff;
   logic [7:0]    nxt_supply_prev_ff;
   logic [5:0]    status_prev_ff;
   logic [5:0]    nxt_status_prev_ff;
   logic          gp1_prev_ff;
   logic          nxt_gp1_prev_ff;
   logic          gp2_prev_ff;
   logic          nxt_gp2_prev_ff;

   // Control and event state
   logic [7:0]    fault_mask_ff;
   logic [7:0]    nxt_fault_mask_ff;
   logic [7:0]    mode_ff;
   logic [7:0]    nxt_mode_ff;
   logic [15:0]   event_mask_ff;
   logic [15:0]   nxt_event_mask_ff;
   logic [15:0]   event_latch_ff;
   logic [15:0]   nxt_event_latch_ff;
   logic [3:0]    gp_config_ff;
   logic [3:0]    nxt_gp_config_ff;
   irq_state_type irq_state_ff;
   irq_state_type nxt_irq_state_ff;
   logic          int_n_ff;
   logic          nxt_int_n_ff;
   logic          fault_evt_ff;
   logic          nxt_fault_evt_ff;
   reg_rsp_type   rsp_ff;
   reg_rsp_type   nxt_rsp_ff;

   // Decoded events
   logic [7:0]    supply_change;
   logic [15:0]   event_vec;
   logic [15:0]   event_live;
   logic          reload_any;
   logic          gp1_edge;
   logic          gp2_edge;

   // Input history follows the pins every cycle
   always_comb begin
      nxt_supply_prev_ff = supply_fault_in;
      nxt_status_prev_ff = status_in;
      nxt_gp1_prev_ff    = gp_pin_one;
      nxt_gp2_prev_ff    = gp_pin_two;
   end

   // History registers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         supply_prev_ff <= 8'h00;
         status_prev_ff <= 6'h00;
         gp1_prev_ff    <= 1'b0;
         gp2_prev_ff    <= 1'b0;
      end else begin
         supply_prev_ff <= nxt_supply_prev_ff;
         status_prev_ff <= nxt_status_prev_ff;
         gp1_prev_ff    <= nxt_gp1_prev_ff;
         gp2_prev_ff    <= nxt_gp2_prev_ff;
      end
   end

   // Toggle and edge detection
   always_comb begin
      supply_change = (supply_fault_in ^ supply_prev_ff) & ~fault_mask_ff;
      gp1_edge = gp_edge(gp_config_ff[`GP1_INPUT_BIT], gp_config_ff[`GP1_RISING_BIT],
                         gp_pin_one, gp1_prev_ff);
      gp2_edge = gp_edge(gp_config_ff[`GP2_INPUT_BIT], gp_config_ff[`GP2_RISING_BIT],
                         gp_pin_two, gp2_prev_ff);
      event_vec = {gp2_edge, gp1_edge, status_in ^ status_prev_ff,
                   supply_fault_in ^ supply_prev_ff};
      event_live = event_vec & ~event_mask_ff;
      reload_any = defaults_reload | fault_evt_ff;
   end

   // Register file, self-clearing requests and interrupt latching
   always_comb begin
      nxt_fault_mask_ff  = fault_mask_ff;
      nxt_mode_ff        = mode_ff;
      nxt_event_mask_ff  = event_mask_ff;
      nxt_event_latch_ff = event_latch_ff;
      nxt_gp_config_ff   = gp_config_ff;
      nxt_irq_state_ff   = irq_state_ff;
      nxt_fault_evt_ff   = |supply_change;
      nxt_rsp_ff         = '{rd_valid: reg_req.rd, rd_data: 8'h00};
      // Requests last one cycle
      nxt_mode_ff[`MODE_SLEEP_BIT]    = 1'b0;
      nxt_mode_ff[`MODE_SOFT_RST_BIT] = 1'b0;
      if (reg_req.wr) begin
         unique case (reg_req.addr)
            `ADDR_FAULT_MASK:   nxt_fault_mask_ff = reg_req.wdata;
            `ADDR_MODE_CONTROL: nxt_mode_ff = reg_req.wdata;
            `ADDR_EVENT_MASK1:  nxt_event_mask_ff[7:0] = reg_req.wdata;
            `ADDR_EVENT_MASK2:  nxt_event_mask_ff[15:8] = reg_req.wdata;
            `ADDR_EVENT_LATCH1: nxt_event_latch_ff[7:0] =
                                   event_latch_ff[7:0] & ~reg_req.wdata;
            `ADDR_EVENT_LATCH2: nxt_event_latch_ff[15:8] =
                                   event_latch_ff[15:8] & ~reg_req.wdata;
            `ADDR_GP_CONFIG:    nxt_gp_config_ff = reg_req.wdata[3:0];
            default: ;
         endcase
      end
      // Defaults reload wins over a host write
      if (reload_any) begin
         nxt_fault_mask_ff = `RST_FAULT_MASK;
         nxt_mode_ff       = `RST_MODE_CONTROL;
         nxt_event_mask_ff = `RST_EVENT_MASK;
         nxt_gp_config_ff  = `RST_GP_CONFIG;
      end
      // Interrupt sequencing
      unique case (irq_state_ff)
         IRQ_IDLE: begin
            if (|event_live) begin
               nxt_event_latch_ff = nxt_event_latch_ff | event_live;
               nxt_irq_state_ff   = IRQ_HELD;
            end
         end
         IRQ_HELD: begin
            if (nxt_event_latch_ff == 16'h0000) begin
               nxt_irq_state_ff = IRQ_IDLE;
            end
         end
      endcase
      // Interrupt pin lags the state by one cycle
      nxt_int_n_ff = (irq_state_ff == IRQ_IDLE);
      // Read answer
      if (reg_req.rd) begin
         unique case (reg_req.addr)
            `ADDR_SUPPLY_STATUS: nxt_rsp_ff.rd_data = supply_prev_ff;
            `ADDR_FAULT_MASK:    nxt_rsp_ff.rd_data = fault_mask_ff;
            `ADDR_MODE_CONTROL:  nxt_rsp_ff.rd_data = mode_ff;
            `ADDR_EVENT_MASK1:   nxt_rsp_ff.rd_data = event_mask_ff[7:0];
            `ADDR_EVENT_MASK2:   nxt_rsp_ff.rd_data = event_mask_ff[15:8];
            `ADDR_EVENT_LATCH1:  nxt_rsp_ff.rd_data = event_latch_ff[7:0];
            `ADDR_EVENT_LATCH2:  nxt_rsp_ff.rd_data = event_latch_ff[15:8];
            `ADDR_GP_CONFIG:     nxt_rsp_ff.rd_data = {4'h0, gp_config_ff};
            default:             nxt_rsp_ff.rd_data = 8'h00;
         endcase
      end
   end

   // State registers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         fault_mask_ff  <= `RST_FAULT_MASK;
         mode_ff        <= `RST_MODE_CONTROL;
         event_mask_ff  <= `RST_EVENT_MASK;
         event_latch_ff <= `RST_EVENT_LATCH;
         gp_config_ff   <= `RST_GP_CONFIG;
         irq_state_ff   <= IRQ_IDLE;
         int_n_ff       <= 1'b1;
         fault_evt_ff   <= 1'b0;
         rsp_ff         <= '{rd_valid: 1'b0, rd_data: 8'h00};
      end else begin
         fault_mask_ff  <= nxt_fault_mask_ff;
         mode_ff        <= nxt_mode_ff;
         event_mask_ff  <= nxt_event_mask_ff;
         event_latch_ff <= nxt_event_latch_ff;
         gp_config_ff   <= nxt_gp_config_ff;
         irq_state_ff   <= nxt_irq_state_ff;
         int_n_ff       <= nxt_int_n_ff;
         fault_evt_ff   <= nxt_fault_evt_ff;
         rsp_ff         <= nxt_rsp_ff;
      end
   end

   // Outputs
   assign buck_standby           = mode_ff[`MODE_STANDBY_BIT];
   assign sleep_req              = mode_ff[`MODE_SLEEP_BIT];
   assign soft_reset_req         = mode_ff[`MODE_SOFT_RST_BIT];
   assign led_boost_low_freq_osc = mode_ff[`MODE_LF_OSC_BIT];
   assign supply_fault_evt       = fault_evt_ff;
   assign int_n                  = int_n_ff;
   assign reg_rsp                = rsp_ff;

   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   // Mode write that no reload overrides
   logic mode_wr;
   assign mode_wr = reg_req.wr && (reg_req.addr == `ADDR_MODE_CONTROL) && !reload_any;

   property p_standby;
      mode_wr && reg_req.wdata[`MODE_STANDBY_BIT] |=> buck_standby;
   endproperty
   a_standby: assert property (p_standby) else $error("standby not applied");

   sequence s_one_pulse(sig);
      sig ##1 !sig;
   endsequence

   property p_sleep;
      mode_wr && reg_req.wdata[`MODE_SLEEP_BIT] |=> s_one_pulse(sleep_req);
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep request not one pulse");

   property p_soft_rst;
      mode_wr && reg_req.wdata[`MODE_SOFT_RST_BIT] |=> s_one_pulse(soft_reset_req);
   endproperty
   a_soft_rst: assert property (p_soft_rst) else $error("reset request wrong");

   property p_flag_clear;
      reload_any |=> !mode_ff[`MODE_FLAG_BIT];
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

   property p_fault_evt;
      (|supply_change) |=> supply_fault_evt ##1 !mode_ff[`MODE_FLAG_BIT];
   endproperty
   a_fault_evt: assert property (p_fault_evt) else $error("supply fault missed");

   property p_mask_reset;
      $fell(rst) |-> fault_mask_ff == 8'hFF;
   endproperty
   a_mask_reset: assert property (p_mask_reset) else $error("mask not masked");

   property p_latch_hold;
      irq_state_ff == IRQ_HELD && !reg_req.wr |=> $stable(event_latch_ff);
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("latch changed");

   sequence s_latch_then_low;
      (event_latch_ff != 16'h0000) ##1 !int_n;
   endsequence

   property p_int_order;
      irq_state_ff == IRQ_IDLE && (|event_live) |=> s_latch_then_low;
   endproperty
   a_int_order: assert property (p_int_order) else $error("interrupt order wrong");

   property p_release;
      irq_state_ff == IRQ_HELD && nxt_event_latch_ff == 16'h0000 |=> ##1 int_n;
   endproperty
   a_release: assert property (p_release) else $error("interrupt not released");

   // Host write lands in the supply fault mask
   property p_mask_write;
      reg_req.wr && (reg_req.addr == `ADDR_FAULT_MASK) && !reload_any
         |=> fault_mask_ff == $past(reg_req.wdata);
   endproperty
   a_mask_write: assert property (p_mask_write) else $error("fault mask write lost");

   // Latched causes keep the interrupt low
   property p_int_low;
      event_latch_ff != 16'h0000 |=> !int_n;
   endproperty
   a_int_low: assert property (p_int_low) else $error("interrupt high while latched");

   // Reload brings the masks back to power-up values
   property p_reload_masks;
      reload_any |=> fault_mask_ff == `RST_FAULT_MASK && event_mask_ff == `RST_EVENT_MASK;
   endproperty
   a_reload_masks: assert property (p_reload_masks) else $error("masks not reloaded");

   // Every read strobe is answered on the next cycle
   property p_rd_answer;
      reg_req.rd |=> reg_rsp.rd_valid;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read not answered");

   // General pin one not set as input never latches a cause
   property p_gp_idle;
      irq_state_ff == IRQ_IDLE && !gp_config_ff[`GP1_INPUT_BIT] |=> !event_latch_ff[14];
   endproperty
   a_gp_idle: assert property (p_gp_idle) else $error("pin edge latched");

endmodule : mode_control_supply_fault_monitor

// ===== design/fault_monitor_defines.svh
// Register map, field positions and reset values of the mode and fault monitor
// Overview of operation
// - Mode bit 7 set puts both buck converters into standby; zero leaves them normal.
// - Mode bit 6 written one requests sleep, then clears itself.
// - Mode bit 0 written one requests reset mode, then clears itself.
// - Defaults reload or supply fault clears the defaults-not-loaded flag to zero.
// - Supply status at 0x02 is read-only, one bit per supply, one is fault.
// - Supply fault mask at 0x07 is read/write, one masks that supply.
// - Any unmasked supply status change raises a supply-fault event.
// - Supply, charger, battery, thermal and converter status bits are interrupt sources.
// - First two general pins, as inputs, interrupt on a chosen edge.
// - Host-writable event masks select which sources may interrupt.
// - An unmasked toggle first sets its bits in the two event latches.
// - After latching, the active-low interrupt output falls.
// - While in IRQ_HELD, latches change only by host clears and new toggles are ignored.
// - All supply fault mask bits come out of reset masked.
`ifndef FAULT_MONITOR_DEFINES_SVH
`define FAULT_MONITOR_DEFINES_SVH
// Register addresses
`define ADDR_SUPPLY_STATUS 8'h02
`define ADDR_FAULT_MASK    8'h07
`define ADDR_MODE_CONTROL  8'h08
`define ADDR_EVENT_MASK1   8'h0C
`define ADDR_EVENT_MASK2   8'h0D
`define ADDR_EVENT_LATCH1  8'h0E
`define ADDR_EVENT_LATCH2  8'h0F
`define ADDR_GP_CONFIG     8'h10
// Mode-control field positions
`define MODE_STANDBY_BIT   7
`define MODE_SLEEP_BIT     6
`define MODE_LF_OSC_BIT    3
`define MODE_FLAG_BIT      1
`define MODE_SOFT_RST_BIT  0
// General pin config field positions
`define GP1_INPUT_BIT      0
`define GP1_RISING_BIT     1
`define GP2_INPUT_BIT      2
`define GP2_RISING_BIT     3
// Reset values
`define RST_FAULT_MASK     8'hFF
`define RST_MODE_CONTROL   8'h00
`define RST_EVENT_MASK     16'hFFFF
`define RST_EVENT_LATCH    16'h0000
`define RST_GP_CONFIG      4'h0
`endif

// ===== design/fault_monitor_pkg.sv
// Types shared by the mode and fault monitor
package fault_monitor_pkg;

   // Register access from the serial engine
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_type;

   // Read answer
   typedef struct packed {
      logic       rd_valid;
      logic [7:0] rd_data;
   } reg_rsp_type;

   // Interrupt controller state
   typedef enum logic {
      IRQ_IDLE = 1'b0,
      IRQ_HELD = 1'b1
   } irq_state_type;

endpackage : fault_monitor_pkg

// ===== test/host_model.sv
// Host register master model driving the block's register port
`timescale 1ns/100ps
module host_model
   import fault_monitor_pkg::*;
(
   input  wire logic        clk_sys,
   output reg_req_type      reg_req,
   input  wire reg_rsp_type reg_rsp
);
   // Bus idle from time zero
   initial reg_req = '0;

   // One write strobe over one rising edge, then one idle cycle
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge clk_sys);
      reg_req = '0;
      @(negedge clk_sys);
   endtask : wr

   // One read strobe, data taken with its valid flag, then one idle cycle
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge clk_sys);
      d = (reg_rsp.rd_valid === 1'b1) ? reg_rsp.rd_data : 8'hXX;
      reg_req = '0;
      @(negedge clk_sys);
   endtask : rd
endmodule : host_model

// ===== test/mode_control_supply_fault_monitor_tb.sv
// Self-checking bench for the mode and supply fault monitor
`timescale 1ns/100ps
module mode_control_supply_fault_monitor_tb;
   import fault_monitor_pkg::*;
   logic        clk_sys, rst, gp_pin_one, gp_pin_two, defaults_reload;
   reg_req_type reg_req;
   reg_rsp_type reg_rsp;
   logic [7:0]  supply_fault_in, v;
   logic [5:0]  status_in;
   logic        buck_standby, sleep_req, soft_reset_req, led_osc, fault_evt, int_n;
   int          n_fail, compares, n_sleep, n_srst, n_evt;

   mode_control_supply_fault_monitor dut (
      .clk_sys(clk_sys), .rst(rst), .reg_req(reg_req), .reg_rsp(reg_rsp),
      .supply_fault_in(supply_fault_in), .status_in(status_in),
      .gp_pin_one(gp_pin_one), .gp_pin_two(gp_pin_two), .defaults_reload(defaults_reload),
      .buck_standby(buck_standby), .sleep_req(sleep_req), .soft_reset_req(soft_reset_req),
      .led_boost_low_freq_osc(led_osc), .supply_fault_evt(fault_evt), .int_n(int_n));

   host_model host (.clk_sys(clk_sys), .reg_req(reg_req), .reg_rsp(reg_rsp));

   // 200 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   // Pulse counters, sampled before the edge's own updates
   always @(posedge clk_sys) begin
      n_sleep += (sleep_req === 1'b1);
      n_srst += (soft_reset_req === 1'b1);
      n_evt += (fault_evt === 1'b1);
   end

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      host.rd(a, v);
      chk($sformatf("reg %h", a), e, v);
   endtask : rchk

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : cyc

   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : tally_and_finish

   // Watchdog against a hung run
   initial begin
      #20000;
      n_fail++;
      $display("MISMATCH watchdog expected end seen timeout");
      tally_and_finish();
   end

   // Main test sequence
   initial begin
      rst = 1'b1;
      supply_fault_in = 8'h00;
      status_in = 6'h00;
      gp_pin_one = 1'b0;
      gp_pin_two = 1'b0;
      defaults_reload = 1'b0;
      cyc(6);
      rst = 1'b0;
      cyc(1);
      rchk(8'h07, 8'hFF);
      rchk(8'h08, 8'h00);
      rchk(8'h20, 8'h00);
      $display("test reset values done");
      host.wr(8'h08, 8'h80);
      chk("buck_standby", 8'h01, {7'h00, buck_standby});
      n_sleep = 0;
      n_srst = 0;
      host.wr(8'h08, 8'hC1);
      cyc(3);
      chk("sleep pulses", 8'h01, n_sleep[7:0]);
      chk("reset pulses", 8'h01, n_srst[7:0]);
      rchk(8'h08, 8'h80);
      host.wr(8'h08, 8'h36);
      cyc(3);
      chk("pulses after spare bits", 8'h02, n_sleep[7:0] + n_srst[7:0]);
      chk("outputs", 8'h00, {6'h00, buck_standby, led_osc});
      rchk(8'h08, 8'h36);
      host.wr(8'h08, 8'h08);
      chk("standby off osc on", 8'h01, {6'h00, buck_standby, led_osc});
      $display("test mode control done");
      supply_fault_in = 8'h5A;
      host.wr(8'h02, 8'h00);
      rchk(8'h02, 8'h5A);
      $display("test status read-only done");
      host.wr(8'h0D, 8'hFE);
      status_in = 6'h04;
      cyc(4);
      chk("int_n masked", 8'h01, {7'h00, int_n});
      status_in = 6'h05;
      cyc(3);
      chk("int_n raised", 8'h00, {7'h00, int_n});
      rchk(8'h0F, 8'h01);
      rchk(8'h0E, 8'h00);
      status_in = 6'h04;
      cyc(3);
      rchk(8'h0F, 8'h01);
      chk("int_n held", 8'h00, {7'h00, int_n});
      host.wr(8'h0F, 8'h01);
      cyc(2);
      chk("int_n released", 8'h01, {7'h00, int_n});
      $display("test interrupt done");
      host.wr(8'h10, 8'h07);
      host.wr(8'h0D, 8'h3F);
      gp_pin_two = 1'b1;
      cyc(3);
      chk("int_n wrong edge", 8'h01, {7'h00, int_n});
      gp_pin_one = 1'b1;
      cyc(3);
      rchk(8'h0F, 8'h40);
      host.wr(8'h0F, 8'h40);
      cyc(2);
      gp_pin_two = 1'b0;
      cyc(3);
      rchk(8'h0F, 8'h80);
      host.wr(8'h0F, 8'h80);
      cyc(2);
      chk("int_n after pins", 8'h01, {7'h00, int_n});
      $display("test general pins done");
      host.wr(8'h08, 8'h02);
      host.wr(8'h07, 8'h7F);
      n_evt = 0;
      supply_fault_in = 8'h5B;
      cyc(3);
      chk("masked fault events", 8'h00, n_evt[7:0]);
      supply_fault_in = 8'hDB;
      cyc(3);
      chk("fault events", 8'h01, n_evt[7:0]);
      rchk(8'h07, 8'hFF);
      rchk(8'h08, 8'h00);
      host.wr(8'h08, 8'h02);
      defaults_reload = 1'b1;
      cyc(1);
      defaults_reload = 1'b0;
      cyc(1);
      rchk(8'h08, 8'h00);
      host.wr(8'h0C, 8'hFE);
      supply_fault_in = 8'hDA;
      cyc(3);
      chk("int_n supply", 8'h00, {7'h00, int_n});
      rchk(8'h0E, 8'h01);
      chk("masked supply events", 8'h01, n_evt[7:0]);
      host.wr(8'h0E, 8'h01);
      cyc(2);
      chk("int_n after supply", 8'h01, {7'h00, int_n});
      $display("test supply fault done");
      tally_and_finish();
   end
endmodule : mode_control_supply_fault_monitor_tb
